// ---- verilog/pmicre_pkg.sv ----
// package: register map, field layout, reset values and key codes of the rail enable bank
`default_nettype none
package pmicre_pkg;

    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_FLAGS = 8'h07;
    localparam logic [7:0] IDX_KEY = 8'h10;
    localparam logic [7:0] IDX_CONV = 8'h11;
    localparam logic [7:0] IDX_SWOUT = 8'h12;
    localparam int BYTE_ADDR_SHIFT = 2;

    // ========================================================
    // field positions
    localparam int FLAG_BUCK1_POS = 0;
    localparam int CONV_BUCK1_POS = 0;
    localparam int CONV_BUCK5_POS = 4;
    localparam int CONV_BUCK6_POS = 5;
    localparam int CONV_USED_W = 6;
    localparam int SEQ_CONV_W = 5;
    localparam int SW_LDO_POS = 0;
    localparam int SW_LS1_POS = 1;
    localparam int SW_LS2_POS = 2;
    localparam int SW_LS3_POS = 3;
    localparam int SW_GP_LSB = 4;
    localparam int GP_COUNT = 3;
    localparam int SW_USED_W = 7;
    localparam int REG_W = 8;

    // ========================================================
    // reset values
    localparam logic [7:0] CONV_RESET = 8'h00;
    localparam logic [7:0] SWOUT_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] KEY_READ_VALUE = 8'h00;
    localparam logic SEAL_RESET = 1'b1;

    // ========================================================
    // key codes written to the unlock key register; values are arbitrary
    localparam logic [7:0] KEY_UNLOCK = 8'hA5;
    localparam logic [7:0] KEY_SEAL_BREAK = 8'h3C;
    localparam logic [7:0] KEY_PROG_DEFAULTS = 8'hC3;

    // ========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ---- verilog/pmicre_rst_sync.sv ----
// reset release synchroniser: asynchronous assert, two-flop release
`default_nettype none
module pmicre_rst_sync (
    // clock and raw reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // synchronised reset
    output logic rst_sync_n
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } pmicre_rsync_s;

    pmicre_rsync_s st;
    pmicre_rsync_s next_st;

    always_comb begin
        next_st.stage1 = 1'b1;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rst_sync_n = st.stage2;
endmodule
`default_nettype wire

// ---- verilog/pmicre_rail_regs.sv ----
// rail enable register bank with axi4-lite slave, key gating and sequencer overrides
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module pmicre_rail_regs
    import pmicre_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power sequencer updates
    input wire logic seq_load,
    input wire logic [SEQ_CONV_W-1:0] seq_buck_on,
    input wire logic seq_ls1_on,
    input wire logic seq_ldo_on,
    // power-up report from the state machine
    input wire logic pwrup_done,
    input wire logic pwrup_from_suspend,
    input wire logic buck1_on_in_suspend,
    // converter enables
    output logic buck1_on,
    output logic buck2_on,
    output logic buck3_on,
    output logic buckboost_on,
    output logic buck5_on,
    output logic buck6_on,
    // switch and regulator enables
    output logic low_volt_switch_on,
    output logic five_volt_switch_on,
    output logic high_volt_switch_on,
    output logic linear_reg_on,
    // general-purpose outputs, open drain
    output logic [GP_COUNT-1:0] gp_out,
    output logic [GP_COUNT-1:0] gp_oe,
    // seal and default programming
    output logic factory_seal_intact,
    output logic defaults_prog_pulse,
    // suspend flag
    output logic buck1_kept_in_suspend
);
    // ========================================================
    // elaboration check
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr_w
        $error("pmicre_rail_regs: ADDR_W must lie in 7..32");
    end
    if (SW_GP_LSB + GP_COUNT != SW_USED_W) begin : g_bad_gp_layout
        $error("pmicre_rail_regs: gp field must end at the top used switch bit");
    end
    if (CONV_BUCK1_POS + SEQ_CONV_W != CONV_BUCK6_POS) begin : g_bad_seq_w
        $error("pmicre_rail_regs: sequencer field must stop below buck6");
    end

    // ========================================================
    // state
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [7:0] wbyte;
        logic wbyte_en;
        logic unlocked;
        logic seal;
        logic prog_pulse;
        logic [REG_W-1:0] conv;
        logic [REG_W-1:0] swout;
        logic [REG_W-1:0] flags;
        logic [GP_COUNT-1:0] gp_out;
        logic [GP_COUNT-1:0] gp_oe;
    } pmicre_state_s;

    pmicre_state_s st;
    pmicre_state_s next_st;
    logic rst_sync_n;

    pmicre_rst_sync pmicre_rst_sync_i (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // ========================================================
    // address decode helpers
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        logic [ADDR_W-1:0] want;
        want = ADDR_W'({24'h000000, idx}) << BYTE_ADDR_SHIFT;
        return addr == want;
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        return addr_is(addr, IDX_FLAGS) || addr_is(addr, IDX_KEY) ||
            addr_is(addr, IDX_CONV) || addr_is(addr, IDX_SWOUT);
    endfunction

    // ========================================================
    // converter write filter
    function automatic logic [REG_W-1:0] conv_filter(input logic [REG_W-1:0] old_v,
                                                     input logic [REG_W-1:0] new_v,
                                                     input logic seal_v);
        logic [REG_W-1:0] res;
        res = '0;
        res[CONV_USED_W-1:0] = new_v[CONV_USED_W-1:0];
        if (seal_v) begin
            res[CONV_BUCK5_POS] = new_v[CONV_BUCK5_POS] | old_v[CONV_BUCK5_POS];
            res[CONV_BUCK6_POS] = new_v[CONV_BUCK6_POS] | old_v[CONV_BUCK6_POS];
        end
        return res;
    endfunction

    logic wr_key;
    logic wr_conv;
    logic wr_swout;
    logic [REG_W-1:0] wr_conv_val;
    logic [REG_W-1:0] wr_swout_val;
    logic [REG_W-1:0] seq_conv_val;
    logic [REG_W-1:0] rd_val;

    always_comb begin
        next_st = st;
        next_st.prog_pulse = 1'b0;
        wr_key = 1'b0;
        wr_conv = 1'b0;
        wr_swout = 1'b0;
        wr_conv_val = st.conv;
        wr_swout_val = st.swout;
        seq_conv_val = st.conv;
        rd_val = '0;

        // ====================================================
        // write channel capture, either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wbyte = s_axi_wdata[7:0];
            // only byte 0 carries a register
            next_st.wbyte_en = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // ====================================================
        // write execution once both halves are held
        if (st.aw_held && st.w_held && !st.bvalid) begin
            // both halves held: execute now, answer on the next edge
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
            wr_key = addr_is(st.awaddr, IDX_KEY) && st.wbyte_en;
            if (addr_is(st.awaddr, IDX_CONV) || addr_is(st.awaddr, IDX_SWOUT)) begin
                if (st.unlocked) begin
                    wr_conv = addr_is(st.awaddr, IDX_CONV) && st.wbyte_en;
                    wr_swout = addr_is(st.awaddr, IDX_SWOUT) && st.wbyte_en;
                    // single use, so a stray second write cannot slip through
                    next_st.unlocked = 1'b0;
                end else begin
                    // refused write leaves every register untouched
                    next_st.bresp = RESP_SLVERR;
                end
            end
        end

        // ====================================================
        // key register actions
        if (wr_key) begin
            next_st.unlocked = 1'b0;
            if (st.wbyte == KEY_UNLOCK) begin
                next_st.unlocked = 1'b1;
            end
            if (st.unlocked && st.wbyte == KEY_SEAL_BREAK) begin
                next_st.seal = 1'b0;
            end
            if (st.unlocked && st.wbyte == KEY_PROG_DEFAULTS) begin
                next_st.prog_pulse = 1'b1;
            end
        end

        // ====================================================
        // converter enables
        // one enable per converter
        if (wr_conv) begin
            wr_conv_val = conv_filter(st.conv, st.wbyte, st.seal);
        end
        next_st.conv = wr_conv_val;
        if (seq_load) begin
            seq_conv_val = wr_conv_val;
            seq_conv_val[CONV_BUCK1_POS +: SEQ_CONV_W] = seq_buck_on;
            // seal filter again: the sequencer may not drop buck5/buck6 either
            next_st.conv = conv_filter(wr_conv_val, seq_conv_val, st.seal);
        end

        // ====================================================
        // switch and output enables
        // switch register layout
        if (wr_swout) begin
            wr_swout_val = '0;
            wr_swout_val[SW_USED_W-1:0] = st.wbyte[SW_USED_W-1:0];
        end
        next_st.swout = wr_swout_val;
        if (seq_load) begin
            next_st.swout[SW_LS1_POS] = seq_ls1_on;
            next_st.swout[SW_LDO_POS] = seq_ldo_on;
        end
        next_st.gp_out = '0;
        next_st.gp_oe = ~next_st.swout[SW_GP_LSB +: GP_COUNT];

        // ====================================================
        // suspend flag, refreshed at every power-up
        // set only on resume with buck1
        if (pwrup_done) begin
            // whole word rewritten so unused flag bits stay zero
            next_st.flags = FLAG_RESET;
            next_st.flags[FLAG_BUCK1_POS] = pwrup_from_suspend && buck1_on_in_suspend;
        end

        // a held half or an unanswered write blocks new requests
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;

        // ====================================================
        // read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            if (addr_is(s_axi_araddr, IDX_KEY)) begin
                rd_val = KEY_READ_VALUE;
            end else if (addr_is(s_axi_araddr, IDX_CONV)) begin
                rd_val = st.conv;
            end else if (addr_is(s_axi_araddr, IDX_SWOUT)) begin
                rd_val = st.swout;
            end else if (addr_is(s_axi_araddr, IDX_FLAGS)) begin
                rd_val = st.flags;
            end
            next_st.rvalid = 1'b1;
            // decoded at the taking edge; stands until rready
            next_st.rdata = {24'h000000, rd_val};
            next_st.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;
    end

    // ========================================================
    // state register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '0;
            st.seal <= SEAL_RESET;
            st.conv <= CONV_RESET;
            st.swout <= SWOUT_RESET;
            st.flags <= FLAG_RESET;
            // gp pins drive low from reset, as bits at zero ask
            st.gp_oe <= '1;
            st.bresp <= RESP_OKAY;
            st.rresp <= RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // outputs, all straight from the state register
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    assign buck1_on = st.conv[CONV_BUCK1_POS];
    assign buck2_on = st.conv[CONV_BUCK1_POS + 1];
    assign buck3_on = st.conv[CONV_BUCK1_POS + 2];
    assign buckboost_on = st.conv[CONV_BUCK1_POS + 3];
    assign buck5_on = st.conv[CONV_BUCK5_POS];
    assign buck6_on = st.conv[CONV_BUCK6_POS];

    assign low_volt_switch_on = st.swout[SW_LS1_POS];
    assign five_volt_switch_on = st.swout[SW_LS2_POS];
    assign high_volt_switch_on = st.swout[SW_LS3_POS];
    assign linear_reg_on = st.swout[SW_LDO_POS];

    assign gp_out = st.gp_out;
    assign gp_oe = st.gp_oe;

    assign factory_seal_intact = st.seal;
    assign defaults_prog_pulse = st.prog_pulse;
    assign buck1_kept_in_suspend = st.flags[FLAG_BUCK1_POS];
endmodule
`default_nettype wire

// ---- tb/pmicre_rail_regs_sva.sv ----
// checker: port-level assertions for the rail enable register bank
`default_nettype none
module pmicre_rail_regs_sva
    import pmicre_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // read answer
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sequencer and power-up report
    input wire logic seq_load,
    input wire logic [SEQ_CONV_W-1:0] seq_buck_on,
    input wire logic seq_ls1_on,
    input wire logic seq_ldo_on,
    input wire logic pwrup_done,
    input wire logic pwrup_from_suspend,
    input wire logic buck1_on_in_suspend,
    // enables, outputs and flags
    input wire logic buck1_on,
    input wire logic buck2_on,
    input wire logic buck3_on,
    input wire logic buckboost_on,
    input wire logic buck5_on,
    input wire logic buck6_on,
    input wire logic low_volt_switch_on,
    input wire logic linear_reg_on,
    input wire logic [GP_COUNT-1:0] gp_out,
    input wire logic factory_seal_intact,
    input wire logic buck1_kept_in_suspend
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ====
    // assertions
    a_flag_set_rule: assert property (pwrup_done |=> buck1_kept_in_suspend ==
        $past(pwrup_from_suspend && buck1_on_in_suspend)) else $error("flag value wrong");
    a_flag_held_rule: assert property (!pwrup_done |=> $stable(buck1_kept_in_suspend))
        else $error("flag changed without power-up");
    a_read_data_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
    a_seal_keeps_buck5: assert property ($fell(buck5_on) |-> !$past(factory_seal_intact))
        else $error("buck5 cleared while sealed");
    a_seal_keeps_buck6: assert property ($fell(buck6_on) |-> !$past(factory_seal_intact))
        else $error("buck6 cleared while sealed");
    a_seq_loads_bucks: assert property (seq_load |=>
        {buckboost_on, buck3_on, buck2_on, buck1_on} == $past(seq_buck_on[3:0]))
        else $error("sequencer buck values lost");
    a_gp_drive_low: assert property (gp_out == 3'h0) else $error("gp output driven high");
    a_seq_loads_switch: assert property (seq_load |=> low_volt_switch_on == $past(seq_ls1_on)
        && linear_reg_on == $past(seq_ldo_on)) else $error("sequencer switch values lost");
    a_upper_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule

bind pmicre_rail_regs pmicre_rail_regs_sva pmicre_rail_regs_sva_i (.*);
`default_nettype wire

// ---- tb/test_pmic_rail_enable_registers.sv ----
// testbench: register access, key gating, seal, sequencer and power-up flag
`default_nettype none
module test_pmic_rail_enable_registers
    import pmicre_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic seq_load = 1'b0, seq_ls1_on = 1'b0, seq_ldo_on = 1'b0;
    logic [4:0] seq_buck_on = 5'h00;
    logic pwrup_done = 1'b0, pwrup_from_suspend = 1'b0, buck1_on_in_suspend = 1'b0;
    logic buck1_on, buck2_on, buck3_on, buckboost_on, buck5_on, buck6_on;
    logic low_volt_switch_on, five_volt_switch_on, high_volt_switch_on, linear_reg_on;
    logic [2:0] gp_out, gp_oe;
    logic factory_seal_intact, defaults_prog_pulse, buck1_kept_in_suspend;
    logic [33:0] q[$];
    logic [7:0] conv = 8'h00, sw = 8'h00, v;
    logic seal = 1'b1;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, n_pulse = 0;

    pmicre_rail_regs pmicre_rail_regs_i (.*);

    always #5 clk_sys = ~clk_sys;

    // ====
    // comparison and closing
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watches answers; a hang ends in the closing report
    always @(posedge clk_sys) begin
        cycles++;
        if (defaults_prog_pulse)
            n_pulse++;
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, q.pop_front());
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ====
    // bus cycles
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
        bit a, w, b;
        q.push_back({r, 32'h0});
        @(posedge clk_sys);
        s_axi_awaddr <= i << 2;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {a, w, b} = 3'b111;
        while (a || w || b) begin
            @(posedge clk_sys);
            if (a && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (b && s_axi_bvalid)
                s_axi_bready <= 1'b0;
            a = a && !s_axi_awready;
            w = w && !s_axi_wready;
            b = b && !s_axi_bvalid;
        end
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
        bit a, b;
        q.push_back({r, 24'h0, d});
        @(posedge clk_sys);
        s_axi_araddr <= i << 2;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        {a, b} = 2'b11;
        while (a || b) begin
            @(posedge clk_sys);
            if (a && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (b && s_axi_rvalid)
                s_axi_rready <= 1'b0;
            a = a && !s_axi_arready;
            b = b && !s_axi_rvalid;
        end
    endtask

    // unlock, then one protected write
    task automatic uw(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
        wr(IDX_KEY, KEY_UNLOCK, RESP_OKAY);
        wr(i, d, r);
    endtask

    task automatic pins;
        chk({factory_seal_intact, gp_oe, high_volt_switch_on, five_volt_switch_on,
            low_volt_switch_on, linear_reg_on, buck6_on, buck5_on, buckboost_on, buck3_on,
            buck2_on, buck1_on}, {seal, ~sw[6:4], sw[3:0], conv[5:0]});
    endtask

    // ====
    // scenarios
    initial begin
        void'($urandom(83));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(IDX_CONV, 8'h00, RESP_OKAY);
        rd(IDX_SWOUT, 8'h00, RESP_OKAY);
        pins;
        wr(IDX_CONV, 8'h3F, RESP_SLVERR);
        v = $urandom;
        conv = v & 8'h3F;
        uw(IDX_CONV, v, RESP_OKAY);
        rd(IDX_CONV, conv, RESP_OKAY);
        wr(IDX_SWOUT, 8'h7F, RESP_SLVERR);
        conv = conv & 8'h30;
        uw(IDX_CONV, 8'h00, RESP_OKAY);
        pins;
        uw(IDX_KEY, KEY_SEAL_BREAK, RESP_OKAY);
        seal = 1'b0;
        uw(IDX_KEY, KEY_PROG_DEFAULTS, RESP_OKAY);
        rd(IDX_KEY, 8'h00, RESP_OKAY);
        chk(34'(n_pulse), 34'd1);
        repeat (4) begin
            v = $urandom;
            conv = v & 8'h3F;
            uw(IDX_CONV, v, RESP_OKAY);
            v = $urandom;
            sw = v & 8'h7F;
            uw(IDX_SWOUT, v, RESP_OKAY);
            rd(IDX_SWOUT, sw, RESP_OKAY);
            pins;
        end
        // disabled strobe still uses up the unlock
        wr(IDX_KEY, KEY_UNLOCK, RESP_OKAY);
        s_axi_wstrb <= 4'hE;
        wr(IDX_CONV, 8'hFF, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        wr(IDX_CONV, 8'h00, RESP_SLVERR);
        rd(IDX_CONV, conv, RESP_OKAY);
        v = $urandom;
        @(posedge clk_sys);
        seq_buck_on <= v[4:0];
        seq_ls1_on <= v[5];
        seq_ldo_on <= v[6];
        seq_load <= 1'b1;
        @(posedge clk_sys);
        seq_load <= 1'b0;
        conv[4:0] = v[4:0];
        sw[1:0] = {v[5], v[6]};
        rd(IDX_CONV, conv, RESP_OKAY);
        pins;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            {pwrup_from_suspend, buck1_on_in_suspend} <= k[1:0];
            pwrup_done <= 1'b1;
            @(posedge clk_sys);
            pwrup_done <= 1'b0;
            rd(IDX_FLAGS, {7'h0, k == 3}, RESP_OKAY);
        end
        rd(8'h20, 8'h00, RESP_SLVERR);
        conclude();
    end
endmodule
`default_nettype wire
